//--- testbench.sv
// Self-checking bench for the timer event flag block
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	import ttf_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk, arst_n, reg_wr, reg_rd, step, wrap, wa, wb, glob;
	logic       auto_svc, rd_d, ev_irq;
	logic [7:0] addr, wdata, rdata, cnt, cmp_a, cmp_b, e;
	logic [2:0] req, svc, ef;
	logic [7:0] exp_q[$];
	int         n_errors, num_checks, cyc;
	integer     seed;
	ttf_timer_flags uut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.count_value(cnt), .compare_a_value(cmp_a), .compare_b_value(cmp_b),
		.count_step(step), .wrap_pulse(wrap), .wave_a_level(wa),
		.wave_b_level(wb), .global_irq_enable(glob), .match_a_svc(svc[1]),
		.match_b_svc(svc[2]), .wrap_svc(svc[0]), .match_a_irq_req(req[1]),
		.match_b_irq_req(req[2]), .wrap_irq_req(req[0]), .event_irq(ev_irq));
	ttf_core_model core (.ref_clk(ref_clk), .arst_n(arst_n),
		.auto_svc(auto_svc), .req(req), .svc(svc));
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Register read, expected value noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		@(posedge ref_clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask
	// Flag register read against the expected flags
	task automatic rf();
		rd(TTF_FLAG_ADDR, {wa, wb, 3'h0, ef});
	endtask
	// One counter step: bit 0 wraps, bit 1 hits A, bit 2 hits B
	task automatic ev(input logic [2:0] m);
		@(posedge ref_clk);
		wrap <= m[0];
		step <= 1'b1;
		cnt <= m[1] ? cmp_a : (m[2] ? cmp_b : cmp_a + 8'h01);
		@(posedge ref_clk);
		wrap <= 1'b0;
		step <= 1'b0;
		ef = ef | m;
		repeat (2) @(posedge ref_clk);
	endtask
	// Request outputs after they settle
	task automatic crq(input logic [2:0] x);
		#1;
		`CHK(req, x)
	endtask
	// Read answer monitor and hang guard
	always @(posedge ref_clk) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			`CHK(rdata, e)
		end
		rd_d <= reg_rd;
		cyc++;
		if (cyc > 3000) begin
			n_errors++;
			test_done();
		end
	end
	// Main sequence
	initial begin
		seed = 32'h1e044b5b;
		{arst_n, reg_wr, reg_rd, step, wrap, wa, wb, glob, auto_svc} = '0;
		{addr, wdata, cnt, rd_d, ef} = '0;
		cmp_a = $random(seed);
		cmp_b = cmp_a ^ 8'h80;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		rf();
		rd(8'h99, TTF_READ_ZERO);
		repeat (4) begin
			@(posedge ref_clk);
			{wa, wb} <= 2'($random(seed));
			@(posedge ref_clk);
			rf();
		end
		wr(TTF_FLAG_ADDR, 8'hf8);
		rf();
		wr(TTF_ENABLE_ADDR, 8'h07);
		glob <= 1'b1;
		ev(3'h0);
		rf();
		for (int i = 0; i < 3; i++) begin
			ev(3'(1 << i));
			crq(ef);
			rf();
		end
		wr(TTF_FLAG_ADDR, 8'h00);
		rf();
		wr(TTF_FLAG_ADDR, 8'h02);
		ef[1] = 1'b0;
		rf();
		glob <= 1'b0;
		crq(3'h0);
		glob <= 1'b1;
		wr(TTF_FLAG_ADDR, 8'h01);
		ef[0] = 1'b0;
		rf();
		// Wrap pulse and write-one clear reach the flag cell together
		@(posedge ref_clk);
		wrap <= 1'b1;
		@(posedge ref_clk);
		wrap <= 1'b0;
		addr <= TTF_FLAG_ADDR;
		wdata <= 8'h01;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		ef[0] = 1'b1;
		rf();
		auto_svc <= 1'b1;
		repeat (4) @(posedge ref_clk);
		ef = 3'h0;
		crq(3'h0);
		rf();
		auto_svc <= 1'b0;
		ev(3'h2);
		auto_svc <= 1'b1;
		repeat (4) @(posedge ref_clk);
		ef = 3'h0;
		rf();
		auto_svc <= 1'b0;
		ev(3'h4);
		wr(TTF_FLAG_ADDR, 8'h04);
		ef = 3'h0;
		rf();
		wr(TTF_LOG_EN_ADDR, 8'h07);
		#1;
		`CHK(ev_irq, 1'b1)
		rd(TTF_LOG_ADDR, 8'h07);
		wr(TTF_LOG_CLR_ADDR, 8'h07);
		#1;
		`CHK(ev_irq, 1'b0)
		rd(TTF_LOG_CLR_ADDR, 8'h00);
		wr(TTF_LOG_EN_ADDR, 8'h00);
		ev(3'h1);
		`CHK(ev_irq, 1'b0)
		rd(TTF_LOG_ADDR, 8'h01);
		repeat (3) @(posedge ref_clk);
		test_done();
	end
endmodule

//--- ttf_core_model.sv
// Processor core stand-in that services pending timer requests
module ttf_core_model (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       auto_svc,
	input  wire logic [2:0] req,
	output logic [2:0]      svc
);
	timeunit 1ns;
	timeprecision 1ns;
	// One pulse per request; the gap stops a double service
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			svc <= 3'h0;
		else
			svc <= auto_svc ? (req & ~svc) : 3'h0;
	end
endmodule

//--- ttf_event_detect.sv
// Turns counter, compare and wrap inputs into one-cycle event pulses
module ttf_event_detect
	import ttf_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] count_value,
	input  wire logic [7:0] compare_a_value,
	input  wire logic [7:0] compare_b_value,
	input  wire logic       count_step,
	input  wire logic       wrap_pulse,
	ttf_event_if.src        evt
);

	// Registered event pulses
	typedef struct packed {
		logic [TTF_EVENTS-1:0] hit;
	} ttf_det_state_t;

	ttf_det_state_t state_reg; // Current state
	ttf_det_state_t state_next; // Next state

	// Evaluate matches and wrap each cycle
	always_comb begin
		state_next = state_reg;
		state_next.hit[TTF_WRAP_BIT] = wrap_pulse;
		state_next.hit[TTF_MATCH_A_BIT] =
			ttf_hit(count_step, count_value, compare_a_value);
		state_next.hit[TTF_MATCH_B_BIT] =
			ttf_hit(count_step, count_value, compare_b_value);
	end

	// State register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign evt.hit = state_reg.hit;

endmodule

//--- ttf_event_if.sv
// Event pulses passed from the event detector to the flag logic
interface ttf_event_if;
	import ttf_pkg::*;

	logic [TTF_EVENTS-1:0] hit; // One-cycle event pulses, bit per flag

	modport src (output hit);
	modport dst (input hit);
endinterface

//--- ttf_flag_cell.sv
// One sticky flag: hardware set, two clear sources, set wins
module ttf_flag_cell (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic set_evt,
	input  wire logic clr_sw,
	input  wire logic clr_svc,
	output logic      flag
);

	// Held flag
	typedef struct packed {
		logic flag;
	} ttf_cell_state_t;

	ttf_cell_state_t state_reg;  // Current state
	ttf_cell_state_t state_next; // Next state

	// Set takes priority so no event is lost to a clear
	always_comb begin
		state_next = state_reg;
		if (set_evt) begin
			state_next.flag = 1'b1;
		end else if (clr_sw || clr_svc) begin
			state_next.flag = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign flag = state_reg.flag;

endmodule

//--- ttf_flags_assertions.sv
// Port-level checker for the timer event flag block
module ttf_flags_assertions
	import ttf_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       count_step,
	input wire logic       wrap_pulse,
	input wire logic       wave_a_level,
	input wire logic       wave_b_level,
	input wire logic       global_irq_enable,
	input wire logic       match_a_svc,
	input wire logic       match_b_svc,
	input wire logic       wrap_svc,
	input wire logic       match_a_irq_req,
	input wire logic       match_b_irq_req,
	input wire logic       wrap_irq_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Read bus idles at zero outside the answer cycle
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	// Upper bits mirror both wave levels, reserved bits zero
	property p_flag_rd; reg_rd && reg_addr == TTF_FLAG_ADDR |=> reg_rdata[7:3]
		== {$past(wave_a_level), $past(wave_b_level), 3'h0}; endproperty
	a_flag_rd: assert property (p_flag_rd) else $error("bad upper bits");
	// No request while the global flag is clear
	property p_glob; !global_irq_enable |->
		!(match_a_irq_req || match_b_irq_req || wrap_irq_req); endproperty
	a_glob: assert property (p_glob) else $error("req w/o global");
	// Service pulse drops the request next cycle
	property p_a_svc; match_a_svc && !$past(count_step) |=> !match_a_irq_req; endproperty
	a_a_svc: assert property (p_a_svc) else $error("A not serviced");
	property p_b_svc; match_b_svc && !$past(count_step) |=> !match_b_irq_req; endproperty
	a_b_svc: assert property (p_b_svc) else $error("B not serviced");
	property p_w_svc; wrap_svc && !$past(wrap_pulse) |=> !wrap_irq_req; endproperty
	a_w_svc: assert property (p_w_svc) else $error("wrap not serviced");
	// A request only rises from an event, an enable write or the global flag
	property p_a_rise; $rose(match_a_irq_req) |-> $past(count_step, 2)
		|| $past(reg_wr) || $rose(global_irq_enable); endproperty
	a_a_rise: assert property (p_a_rise) else $error("A req no cause");
	property p_b_rise; $rose(match_b_irq_req) |-> $past(count_step, 2)
		|| $past(reg_wr) || $rose(global_irq_enable); endproperty
	a_b_rise: assert property (p_b_rise) else $error("B req no cause");
	property p_w_rise; $rose(wrap_irq_req) |-> $past(wrap_pulse, 2)
		|| $past(reg_wr) || $rose(global_irq_enable); endproperty
	a_w_rise: assert property (p_w_rise) else $error("wrap req no cause");
endmodule

bind ttf_timer_flags ttf_flags_assertions u_chk (.ref_clk(ref_clk),
	.arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .count_step(count_step), .wrap_pulse(wrap_pulse),
	.wave_a_level(wave_a_level), .wave_b_level(wave_b_level),
	.global_irq_enable(global_irq_enable), .match_a_svc(match_a_svc),
	.match_b_svc(match_b_svc), .wrap_svc(wrap_svc),
	.match_a_irq_req(match_a_irq_req), .match_b_irq_req(match_b_irq_req),
	.wrap_irq_req(wrap_irq_req));

//--- ttf_pkg.sv
// Shared addresses, bit positions and reset values of the timer flag block
package ttf_pkg;

	// Register addresses on the plain register port
	localparam logic [7:0] TTF_FLAG_ADDR    = 8'h35; // Event flag register
	localparam logic [7:0] TTF_ENABLE_ADDR  = 8'h6e; // Per-flag request enables
	localparam logic [7:0] TTF_LOG_ADDR     = 8'h36; // Sticky event log, read
	localparam logic [7:0] TTF_LOG_CLR_ADDR = 8'h37; // Event log clear, write
	localparam logic [7:0] TTF_LOG_EN_ADDR  = 8'h38; // Event log irq enables

	// Bit positions inside the event flag register
	localparam int TTF_WRAP_BIT    = 0; // Counter wrap flag
	localparam int TTF_MATCH_A_BIT = 1; // Channel A match flag
	localparam int TTF_MATCH_B_BIT = 2; // Channel B match flag
	localparam int TTF_WAVE_B_BIT  = 6; // Channel B waveform level mirror
	localparam int TTF_WAVE_A_BIT  = 7; // Channel A waveform level mirror

	// Number of event sources: wrap, match A, match B
	localparam int TTF_EVENTS = 3;

	// Values after reset
	localparam logic [7:0] TTF_FLAG_RESET  = 8'h00;
	localparam logic [2:0] TTF_EN_RESET    = 3'h0;
	localparam logic [7:0] TTF_RDATA_RESET = 8'h00;

	// Value returned for reserved bits and unmapped addresses
	localparam logic [7:0] TTF_READ_ZERO = 8'h00;

	// True when the counter has landed on the compare value
	function automatic logic ttf_hit(
		input logic       step,
		input logic [7:0] count,
		input logic [7:0] compare
	);
		return step && (count == compare);
	endfunction

endpackage

//--- ttf_timer_flags.sv
// Timer event flag register with request logic and an event log
module ttf_timer_flags
	import ttf_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	// Counter and compare values from the timer core
	input  wire logic [7:0] count_value,
	input  wire logic [7:0] compare_a_value,
	input  wire logic [7:0] compare_b_value,
	input  wire logic       count_step,
	input  wire logic       wrap_pulse,
	// Waveform levels from the waveform generator
	input  wire logic       wave_a_level,
	input  wire logic       wave_b_level,
	// Processor interrupt handling
	input  wire logic       global_irq_enable,
	input  wire logic       match_a_svc,
	input  wire logic       match_b_svc,
	input  wire logic       wrap_svc,
	output logic            match_a_irq_req,
	output logic            match_b_irq_req,
	output logic            wrap_irq_req,
	// Event log interrupt
	output logic            event_irq
);

	// ------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------

	// All registers owned by this module
	typedef struct packed {
		logic [TTF_EVENTS-1:0] irq_en;  // Request enables, flag layout
		logic [TTF_EVENTS-1:0] log_en;  // Event log interrupt enables
		logic [7:0]            rdata;   // Read data, one cycle after strobe
	} ttf_top_state_t;

	ttf_top_state_t state_reg;  // Current state
	ttf_top_state_t state_next; // Next state

	// ------------------------------------------------------------
	// Internal signals
	// ------------------------------------------------------------

	ttf_event_if evt ();                  // Event pulses from the detector

	logic [TTF_EVENTS-1:0] flags;         // Event flag bits 2..0
	logic [TTF_EVENTS-1:0] log_bits;      // Sticky event log bits
	logic [TTF_EVENTS-1:0] flag_wr_clr;   // Write-one clears of flags
	logic [TTF_EVENTS-1:0] svc_clr;       // Service clears of flags
	logic [TTF_EVENTS-1:0] log_wr_clr;    // Write-one clears of the log
	logic [7:0]            flag_view;     // Flag register as read
	logic                  wr_flag;       // Write to the flag register
	logic                  wr_enable;     // Write to the enable register
	logic                  wr_log_clr;    // Write to the log clear register
	logic                  wr_log_en;     // Write to the log enable register

	// ------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------

	// Compare and wrap events become one-cycle pulses
	ttf_event_detect u_detect (
		.ref_clk         (ref_clk),
		.arst_n          (arst_n),
		.count_value     (count_value),
		.compare_a_value (compare_a_value),
		.compare_b_value (compare_b_value),
		.count_step      (count_step),
		.wrap_pulse      (wrap_pulse),
		.evt             (evt.src)
	);

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------

	// Address match for each writable register
	always_comb begin
		wr_flag    = reg_wr && (reg_addr == TTF_FLAG_ADDR);
		wr_enable  = reg_wr && (reg_addr == TTF_ENABLE_ADDR);
		wr_log_clr = reg_wr && (reg_addr == TTF_LOG_CLR_ADDR);
		wr_log_en  = reg_wr && (reg_addr == TTF_LOG_EN_ADDR);
	end

	// Only ones in the written data clear; zeros leave flags alone
	always_comb begin
		flag_wr_clr = '0;
		if (wr_flag) begin
			flag_wr_clr = reg_wdata[TTF_EVENTS-1:0];
		end
	end

	// Service acknowledges from the interrupt controller
	always_comb begin
		svc_clr = '0;
		svc_clr[TTF_WRAP_BIT]    = wrap_svc;
		svc_clr[TTF_MATCH_A_BIT] = match_a_svc;
		svc_clr[TTF_MATCH_B_BIT] = match_b_svc;
	end

	// Log clears come only through the write-only clear register
	always_comb begin
		log_wr_clr = '0;
		if (wr_log_clr) begin
			log_wr_clr = reg_wdata[TTF_EVENTS-1:0];
		end
	end

	// ------------------------------------------------------------
	// Flag and log storage
	// ------------------------------------------------------------

	// Two flag cells per event, flag and log; bit 0 wrap, 1 match A, 2 match B
	// An event in the same cycle as a clear leaves the flag set
	for (genvar i = 0; i < TTF_EVENTS; i++) begin : g_flag
		// Event flag, cleared by write-one or by service
		ttf_flag_cell u_flag (
			.ref_clk (ref_clk),
			.arst_n  (arst_n),
			.set_evt (evt.hit[i]),
			.clr_sw  (flag_wr_clr[i]),
			.clr_svc (svc_clr[i]),
			.flag    (flags[i])
		);
		// Sticky log bit, cleared only by the clear register
		ttf_flag_cell u_log (
			.ref_clk (ref_clk),
			.arst_n  (arst_n),
			.set_evt (evt.hit[i]),
			.clr_sw  (log_wr_clr[i]),
			.clr_svc (1'b0),
			.flag    (log_bits[i])
		);
	end

	// ------------------------------------------------------------
	// Read view of the flag register
	// ------------------------------------------------------------

	// Waveform mirrors on top, reserved bits zero, flags at bottom
	always_comb begin
		flag_view = TTF_READ_ZERO;
		flag_view[TTF_WAVE_A_BIT] = wave_a_level;
		flag_view[TTF_WAVE_B_BIT] = wave_b_level;
		flag_view[TTF_EVENTS-1:0] = flags;
	end

	// ------------------------------------------------------------
	// Register next state
	// ------------------------------------------------------------

	// Enables, log enables and the read data register
	always_comb begin
		state_next = state_reg;

		// Request enable register, upper bits ignored
		if (wr_enable) begin
			state_next.irq_en = reg_wdata[TTF_EVENTS-1:0];
		end

		// Event log enable register
		if (wr_log_en) begin
			state_next.log_en = reg_wdata[TTF_EVENTS-1:0];
		end

		// Read data holds only in the cycle after a read strobe
		state_next.rdata = TTF_READ_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				// Flag register with live waveform mirrors
				TTF_FLAG_ADDR: begin
					state_next.rdata = flag_view;
				end
				// Enable register reads back
				TTF_ENABLE_ADDR: begin
					state_next.rdata[TTF_EVENTS-1:0] = state_reg.irq_en;
				end
				// Sticky event log
				TTF_LOG_ADDR: begin
					state_next.rdata[TTF_EVENTS-1:0] = log_bits;
				end
				// Log enable register reads back
				TTF_LOG_EN_ADDR: begin
					state_next.rdata[TTF_EVENTS-1:0] = state_reg.log_en;
				end
				// Clear register and unmapped addresses read zero
				default: begin
					state_next.rdata = TTF_READ_ZERO;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// All control state returns to zero on reset
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg.irq_en <= TTF_EN_RESET;
			state_reg.log_en <= TTF_EN_RESET;
			state_reg.rdata  <= TTF_RDATA_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Registered read data
	assign reg_rdata = state_reg.rdata;

	// Requests need flag, its enable and the global interrupt flag
	// Software must read the waveform mirror before routing the pin;
	// this block only exposes the level for that purpose
	always_comb begin
		wrap_irq_req = flags[TTF_WRAP_BIT]
			&& state_reg.irq_en[TTF_WRAP_BIT]
			&& global_irq_enable;
		match_a_irq_req = flags[TTF_MATCH_A_BIT]
			&& state_reg.irq_en[TTF_MATCH_A_BIT]
			&& global_irq_enable;
		match_b_irq_req = flags[TTF_MATCH_B_BIT]
			&& state_reg.irq_en[TTF_MATCH_B_BIT]
			&& global_irq_enable;
	end

	// Level interrupt while any enabled log bit is set
	assign event_irq = |(log_bits & state_reg.log_en);

endmodule
